// ---- hw/ssbg_map.svh ----
`ifndef SSBG_MAP_SVH
`define SSBG_MAP_SVH
`define SSBG_ADDR_STATUS 12'h000
`define SSBG_ADDR_DIVISOR 12'h004
`define SSBG_ADDR_CONTROL 12'h008
`define SSBG_ADDR_TXBUF 12'h00C
`define SSBG_ADDR_RXBUF 12'h010
`define SSBG_BIT_TXEMPTY 7
`define SSBG_BIT_RXFULL 6
`define SSBG_BIT_OVR 5
`define SSBG_BIT_FRM 4
`define SSBG_BIT_PAR 3
`define SSBG_BIT_TXDONE 2
`define SSBG_BIT_RXMP 1
`define SSBG_BIT_TXMP 0
`define SSBG_CTL_TXEN 0
`define SSBG_CTL_RXEN 1
`define SSBG_CTL_CKS_LO 2
`define SSBG_CTL_CKS_HI 3
`define SSBG_CTL_SYNC 4
`define SSBG_CTL_MP 5
`define SSBG_CTL_SKIP 6
`define SSBG_CTL_ENDIRQ 7
`define SSBG_RST_DIVISOR 8'hFF
`define SSBG_RST_CONTROL 8'h00
`define SSBG_ASYNC_BASE 12'h020
`define SSBG_SYNC_BASE 12'h004
`endif

// ---- hw/ssbg_pkg.sv ----
package ssbg_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic mpBit;
    logic frameErr;
    logic parityErr;
  } ssbg_rx_event_type;
  typedef struct packed {
    logic loaded;
    logic lastBit;
  } ssbg_tx_event_type;
endpackage

// ---- hw/ssbg_serial_status.sv ----
`include "ssbg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ssbg_serial_status (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire ssbg_pkg::ssbg_tx_event_type txEvent, // from transmit shifter
  input wire ssbg_pkg::ssbg_rx_event_type rxEvent, // from receive shifter
  output logic [7:0] txData, // tx holding buffer contents
  output logic txPending, // holding buffer awaits the shifter
  output logic txMpBit, // multiproc bit to append
  output logic txEnable, // transmit enable
  output logic rxEnable, // receive enable
  output logic syncMode, // clocked synchronous mode
  output logic bitTick, // one pulse per bit period
  output logic txEndIrq // transmit end request
);
  import ssbg_pkg::*;

  logic txEmpty_reg, rxFull_reg, ovr_reg, frm_reg, par_reg, txDone_reg;
  logic rxMp_reg, txMp_reg;
  logic [5:0] armed_reg;
  logic [7:0] divisor_reg;
  logic [7:0] control_reg;
  logic [7:0] txBuf_reg;
  logic [7:0] rxBuf_reg;
  logic [11:0] psCnt_reg;
  logic [7:0] divCnt_reg;

  // apb decode
  wire access = psel & penable;
  wire wrEn = access & pwrite;
  wire rdEn = access & ~pwrite;
  wire selStatus = paddr == `SSBG_ADDR_STATUS;
  wire selDivisor = paddr == `SSBG_ADDR_DIVISOR;
  wire selControl = paddr == `SSBG_ADDR_CONTROL;
  wire selTxBuf = paddr == `SSBG_ADDR_TXBUF;
  wire selRxBuf = paddr == `SSBG_ADDR_RXBUF;
  wire mapped = selStatus | selDivisor | selControl | selTxBuf | selRxBuf;
  wire wrStatus = wrEn & selStatus;
  wire rdStatus = rdEn & selStatus;
  wire wrTxBuf = wrEn & selTxBuf;
  wire rdRxBuf = rdEn & selRxBuf;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // control fields
  assign txEnable = control_reg[`SSBG_CTL_TXEN];
  assign rxEnable = control_reg[`SSBG_CTL_RXEN];
  assign syncMode = control_reg[`SSBG_CTL_SYNC];
  wire [1:0] cks = {control_reg[`SSBG_CTL_CKS_HI], control_reg[`SSBG_CTL_CKS_LO]};
  wire mpMode = control_reg[`SSBG_CTL_MP];
  wire skipEn = control_reg[`SSBG_CTL_SKIP];
  wire endIrqEn = control_reg[`SSBG_CTL_ENDIRQ];

  wire [7:0] statusView = {txEmpty_reg, rxFull_reg, ovr_reg, frm_reg, par_reg, txDone_reg,
    rxMp_reg, txMp_reg};

  // clear only by writing zero after the flag was read as one
  wire [5:0] flagsNow = statusView[7:2];
  wire [5:0] wrZero = {6{wrStatus}} & ~pwdata[7:2] & armed_reg;
  wire [5:0] armed_next = rdStatus ? (armed_reg | flagsNow) :
    (wrStatus ? 6'h00 : armed_reg);

  // receive event qualification
  wire rxSeen = rxEvent.valid & rxEnable;
  wire skipChar = rxSeen & mpMode & skipEn & ~rxEvent.mpBit;
  wire rxAccept = rxSeen & ~skipChar;
  // a read of the holding buffer in the same cycle frees it for the new character
  wire rxFullHeld = rxFull_reg & ~rdRxBuf;
  wire rxOverrun = rxAccept & rxFullHeld;
  wire rxGood = rxAccept & ~rxFullHeld & ~rxEvent.frameErr & ~rxEvent.parityErr;
  wire skipEnd = rxSeen & mpMode & skipEn & rxEvent.mpBit;

  // status flag next values, set wins over clear
  wire txEmptySet = ~txEnable | txEvent.loaded;
  wire txEmptyClr = wrZero[5] | wrTxBuf;
  wire txEmpty_next = txEmptySet | (txEmpty_reg & ~txEmptyClr);
  wire rxFullClr = wrZero[4] | rdRxBuf;
  wire rxFull_next = rxGood | (rxFull_reg & ~rxFullClr);
  wire ovrClr = wrZero[3];
  wire ovr_next = rxOverrun | (ovr_reg & ~ovrClr);
  wire frmSet = rxAccept & rxEvent.frameErr;
  wire frmClr = wrZero[2];
  wire frm_next = frmSet | (frm_reg & ~frmClr);
  wire parSet = rxAccept & rxEvent.parityErr;
  wire parClr = wrZero[1];
  wire par_next = parSet | (par_reg & ~parClr);
  // last bit only counts as the end when nothing waits in the holding buffer
  wire txDoneSet = ~txEnable | (txEvent.lastBit & txEmpty_reg);
  wire txDoneClr = wrZero[0] | wrTxBuf;
  wire txDone_next = txDoneSet | (txDone_reg & ~txDoneClr);
  wire rxMp_next = rxSeen ? rxEvent.mpBit : rxMp_reg;
  wire txMp_next = wrStatus ? pwdata[`SSBG_BIT_TXMP] : txMp_reg;
  wire wrDivisor = wrEn & selDivisor;

  // skip enable is software-set and hardware-cleared
  wire [7:0] ctlWrite = wrEn & selControl ? pwdata[7:0] : control_reg;
  wire [7:0] control_next = skipEnd ?
    (ctlWrite & ~(8'h01 << `SSBG_CTL_SKIP)) : ctlWrite;

  // baud generator: prescale stage then divisor stage
  wire [11:0] psBase = syncMode ? `SSBG_SYNC_BASE : `SSBG_ASYNC_BASE;
  wire [11:0] psLen = psBase << {cks, 1'b0};
  wire psLast = psCnt_reg >= (psLen - 12'h001);
  wire divLast = divCnt_reg == 8'h00;
  wire [11:0] psCnt_next = psLast ? 12'h000 : psCnt_reg + 12'h001;
  wire [7:0] divCnt_next = ~psLast ? divCnt_reg :
    (divLast ? divisor_reg : divCnt_reg - 8'h01);
  wire tick_next = psLast & divLast;

  // read mux
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (selStatus) begin
      rdByte = statusView;
    end else if (selDivisor) begin
      rdByte = divisor_reg;
    end else if (selControl) begin
      rdByte = control_reg;
    end else if (selTxBuf) begin
      rdByte = txBuf_reg;
    end else if (selRxBuf) begin
      rdByte = rxBuf_reg;
    end
  end
  assign prdata = {24'h000000, rdByte};

  // status flags, one short process each
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txEmpty_reg <= 1'b1;
    end else if (clkEn) begin
      txEmpty_reg <= txEmpty_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxFull_reg <= 1'b0;
    end else if (clkEn) begin
      rxFull_reg <= rxFull_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ovr_reg <= 1'b0;
    end else if (clkEn) begin
      ovr_reg <= ovr_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frm_reg <= 1'b0;
    end else if (clkEn) begin
      frm_reg <= frm_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      par_reg <= 1'b0;
    end else if (clkEn) begin
      par_reg <= par_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txDone_reg <= 1'b1;
    end else if (clkEn) begin
      txDone_reg <= txDone_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxMp_reg <= 1'b0;
    end else if (clkEn) begin
      rxMp_reg <= rxMp_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txMp_reg <= 1'b0;
    end else if (clkEn) begin
      txMp_reg <= txMp_next;
    end
  end

  // arms hold which flags were seen as one by any status read since the last status write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      armed_reg <= 6'h00;
    end else if (clkEn) begin
      armed_reg <= armed_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divisor_reg <= `SSBG_RST_DIVISOR;
    end else if (clkEn & wrDivisor) begin
      divisor_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      control_reg <= `SSBG_RST_CONTROL;
    end else if (clkEn) begin
      control_reg <= control_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txBuf_reg <= 8'h00;
    end else if (clkEn & wrTxBuf) begin
      txBuf_reg <= pwdata[7:0];
    end
  end

  // only good characters reach the holding buffer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxBuf_reg <= 8'h00;
    end else if (clkEn & rxGood) begin
      rxBuf_reg <= rxEvent.data;
    end
  end

  // prescale stage; a shorter new length ends the current count at once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      psCnt_reg <= 12'h000;
    end else if (clkEn) begin
      psCnt_reg <= psCnt_next;
    end
  end

  // divisor stage; a new divisor only takes effect at the next reload
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= `SSBG_RST_DIVISOR;
    end else if (clkEn) begin
      divCnt_reg <= divCnt_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bitTick <= 1'b0;
    end else if (clkEn) begin
      bitTick <= tick_next;
    end
  end

  assign txData = txBuf_reg;
  assign txPending = ~txEmpty_reg;
  assign txMpBit = txMp_reg;
  assign txEndIrq = txDone_reg & endIrqEn;
endmodule
`default_nettype wire

// ---- verification/ssbg_serial_status_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbg_serial_status_sva (
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset
  input wire logic clkEn, // advance
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire ssbg_pkg::ssbg_tx_event_type txEvent, // tx events
  input wire logic txPending, // pending
  input wire logic txMpBit, // mp bit
  input wire logic txEnable, // tx on
  input wire logic bitTick // tick
);
  import ssbg_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire acc = psel && penable && clkEn;
  wire wrSt = acc && pwrite && paddr == 12'h000;
  wire wrTx = acc && pwrite && paddr == 12'h00C;
  wire setT = txEvent.loaded || !txEnable;
  a_tx_loaded: assert property (clkEn && txEvent.loaded |=> !txPending)
    else $error("empty not set on load");
  a_tx_off: assert property (clkEn && !txEnable |=> !txPending)
    else $error("empty not held when off");
  a_tx_write: assert property (wrTx && !setT |=> txPending)
    else $error("data write kept empty");
  a_one_ignored: assert property (wrSt && pwdata[7] && txPending && !setT |=> txPending)
    else $error("empty set by write");
  a_mp_write: assert property (wrSt |=> txMpBit == $past(pwdata[0]))
    else $error("mp bit not written");
  a_err_map: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h010))
    else $error("bad slave error");
  a_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_tick_pulse: assert property (clkEn && bitTick |=> !bitTick)
    else $error("tick too long");
  a_ready_zero: assert property (acc |-> pready)
    else $error("wait state seen");
  a_freeze_tick: assert property (!clkEn |=> $stable(bitTick))
    else $error("tick moved while frozen");
  a_freeze_pend: assert property (!clkEn |=> $stable(txPending))
    else $error("pending moved while frozen");
endmodule
bind ssbg_serial_status ssbg_serial_status_sva u_ssbg_serial_status_sva (.sys_clk, .rstn,
  .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txEvent,
  .txPending, .txMpBit, .txEnable, .bitTick);
`default_nettype wire

// ---- verification/ssbg_line_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbg_line_peer (
  input wire logic sys_clk, // clock
  output var ssbg_pkg::ssbg_tx_event_type txEvent, // shifter events
  output var ssbg_pkg::ssbg_rx_event_type rxEvent // received chars
);
  import ssbg_pkg::*;
  initial begin
    txEvent = '0;
    rxEvent = '0;
  end
  task automatic rx(input logic [7:0] d, input logic m, f, q);
    @(posedge sys_clk);
    rxEvent <= {1'h1, d, m, f, q};
    @(posedge sys_clk);
    rxEvent <= {1'h0, ~d, ~m, 2'h0};
  endtask
  task automatic tx(input logic last);
    @(posedge sys_clk);
    txEvent <= {~last, last};
    @(posedge sys_clk);
    txEvent <= 2'h0;
  endtask
endmodule
`default_nettype wire

// ---- verification/serial_status_and_baud_gen_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_status_and_baud_gen_tb;
  import ssbg_pkg::*;
  logic sys_clk = '0, rstn = '0, psel = '0, penable = '0, pwrite = '0;
  logic clkEn = '1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, sErr, txPending, txMpBit, txEnable, rxEnable, syncMode, bitTick;
  logic txEndIrq;
  logic [7:0] txData;
  ssbg_tx_event_type txEvent;
  ssbg_rx_event_type rxEvent;
  int err_count = 0, n_compared = 0, p;
  initial forever #12.5 sys_clk = ~sys_clk;
  ssbg_serial_status u_ssbg_serial_status (.sys_clk, .rstn, .clkEn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txEvent, .rxEvent, .txData,
    .txPending, .txMpBit, .txEnable, .rxEnable, .syncMode, .bitTick, .txEndIrq);
  ssbg_line_peer u_ssbg_line_peer (.sys_clk, .txEvent, .rxEvent);
  task automatic chk(input logic [31:0] e, g, input logic [11:0] a);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 40);
    rv = prdata;
    sErr = pslverr;
    if (pready !== 1'h1) begin
      err_count++;
      give_verdict;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(e, rv, a);
  endtask
  task automatic tick(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (bitTick !== 1'h1 && c < 9000);
    if (c >= 9000) begin
      err_count++;
      give_verdict;
    end
  endtask
  task automatic baud(input logic [7:0] c, input logic [31:0] e);
    apb(1'h1, 12'h008, {24'h0, c});
    tick(p);
    tick(p);
    tick(p);
    chk(e, p, 12'h004);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    rc(12'h000, 32'h84);
    rc(12'h004, 32'hFF);
    apb(1'h1, 12'h004, 32'hFFFFFF5A);
    rc(12'h004, 32'h5A);
    rc(12'h020, 32'h0);
    chk(32'h1, {31'h0, sErr}, 12'h020);
    $display("test regs done");
    apb(1'h1, 12'h008, 32'h03);
    u_ssbg_line_peer.rx(8'h11, 1'h0, 1'h1, 1'h0);
    u_ssbg_line_peer.rx(8'h22, 1'h0, 1'h0, 1'h1);
    u_ssbg_line_peer.rx(8'h5A, 1'h1, 1'h0, 1'h0);
    u_ssbg_line_peer.rx(8'h33, 1'h0, 1'h0, 1'h0);
    rc(12'h000, 32'hFC);
    rc(12'h010, 32'h5A);
    apb(1'h1, 12'h000, 32'hFF);
    rc(12'h000, 32'hBD);
    apb(1'h1, 12'h000, 32'h01);
    rc(12'h000, 32'h01);
    apb(1'h1, 12'h00C, 32'hA5);
    u_ssbg_line_peer.tx(1'h0);
    rc(12'h000, 32'h81);
    u_ssbg_line_peer.tx(1'h1);
    rc(12'h000, 32'h85);
    apb(1'h1, 12'h00C, 32'h3C);
    @(negedge sys_clk);
    chk(32'h3C, {24'h0, txData}, 12'h00C);
    rc(12'h00C, 32'h3C);
    apb(1'h1, 12'h000, 32'h81);
    rc(12'h000, 32'h01);
    apb(1'h1, 12'h008, 32'h80);
    rc(12'h000, 32'h85);
    @(negedge sys_clk);
    chk(32'h1, {31'h0, txEndIrq}, 12'h008);
    u_ssbg_line_peer.rx(8'h77, 1'h1, 1'h0, 1'h0);
    rc(12'h000, 32'h85);
    apb(1'h1, 12'h008, 32'h62);
    @(negedge sys_clk);
    chk(32'h2, {29'h0, syncMode, rxEnable, txEnable}, 12'h008);
    chk(32'h0, {31'h0, txEndIrq}, 12'h008);
    u_ssbg_line_peer.rx(8'h44, 1'h0, 1'h0, 1'h0);
    u_ssbg_line_peer.rx(8'h66, 1'h1, 1'h0, 1'h0);
    rc(12'h008, 32'h22);
    rc(12'h000, 32'hC7);
    rc(12'h010, 32'h66);
    $display("test flags done");
    apb(1'h1, 12'h004, 32'h01);
    baud(8'h10, 32'h8);
    baud(8'h04, 32'h100);
    baud(8'h1C, 32'h200);
    @(posedge sys_clk);
    clkEn <= 1'h0;
    apb(1'h1, 12'h004, 32'h33);
    rc(12'h004, 32'h01);
    p = 0;
    repeat (600) begin
      @(negedge sys_clk);
      if (bitTick !== 1'h0) p++;
    end
    chk(32'h0, p, 12'h004);
    @(posedge sys_clk);
    clkEn <= 1'h1;
    $display("test baud done");
    give_verdict;
  end
endmodule
`default_nettype wire
